/* File: sim/cid_checker.sv */
// Port assertions for the contact input monitor
`timescale 1ns/100ps
`default_nettype none
module cid_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Field and status
   input wire logic groundFaultDetect,
   input wire logic auxSupplyFail,
   input wire logic internalFault,
   input wire logic errorIndicator,
   input wire logic attention
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_ready_in_access: assert property (
      psel && penable |-> pready) else $error("no ready in access");
   a_gnd_fault_led: assert property (
      groundFaultDetect [*6] |-> errorIndicator)
      else $error("fault indicator not lit");
   a_int_fault_attn: assert property (
      internalFault [*6] |-> attention && errorIndicator)
      else $error("internal fault not reported");
   a_bad_addr_err: assert property (
      psel && !penable && paddr[1:0] != 2'h0 ##1 penable |-> pslverr)
      else $error("unaligned access not refused");
   a_undef_bits_one: assert property (
      psel && !penable && !pwrite && paddr == 8'h34 ##1 penable
      |-> prdata[5:2] == 4'hF) else $error("undefined bits not one");
   a_diag_status: assert property (
      $stable({internalFault, groundFaultDetect, auxSupplyFail}) [*6]
      ##0 psel && !penable && !pwrite && paddr == 8'h34
      |=> prdata[10:8] == $past({internalFault, groundFaultDetect,
      auxSupplyFail})) else $error("diagnostic status wrong");
   a_force_attn: assert property (
      psel && penable && pwrite && paddr == 8'h34 && pwdata[1]
      |-> ##[1:3] attention) else $error("forced error silent");
   a_unconfig_attn: assert property (
      psel && penable && pwrite && paddr == 8'h34 && !pwdata[0]
      |-> ##[1:3] attention) else $error("unconfigure silent");
   c_force: cover property (psel && penable && pwrite && pwdata[1]);
   c_refused: cover property (pslverr && pready);
   c_gnd_led: cover property (groundFaultDetect && errorIndicator);
endmodule // cid_checker

bind cid_contact_input cid_checker u_cid_checker (
   .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .groundFaultDetect(groundFaultDetect), .auxSupplyFail(auxSupplyFail),
   .internalFault(internalFault), .errorIndicator(errorIndicator),
   .attention(attention)
);
`default_nettype wire

/* File: sim/cid_field_model.sv */
// Field side model driving contact and fault detect lines
`timescale 1ns/100ps
`default_nettype none
module cid_field_model (
   // Clock
   input wire logic clock,
   // Detect lines toward the module
   output logic [cid_pkg::NUM_CHANNELS-1:0] currentDetect,
   output logic groundFaultDetect,
   output logic auxSupplyFail,
   output logic internalFault
);
   initial begin
      currentDetect = 16'h0000;
      groundFaultDetect = 1'b0;
      auxSupplyFail = 1'b0;
      internalFault = 1'b0;
   end
   // Set bit means closed contact, current flowing
   task automatic settle(input logic [15:0] c);
      @(posedge clock);
      currentDetect <= c;
   endtask
   // Short change of state, then back to the old contacts
   task automatic bounce(input logic [15:0] c, input int len);
      logic [15:0] keep;
      keep = currentDetect;
      @(posedge clock);
      currentDetect <= c;
      repeat (len) @(posedge clock);
      currentDetect <= keep;
   endtask
   // A leak to earth on any line shows as a fault level
   task automatic faults(input logic g, a, i);
      @(posedge clock);
      groundFaultDetect <= g;
      auxSupplyFail <= a;
      internalFault <= i;
   endtask
endmodule // cid_field_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the contact input monitor
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int FC = 8;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [15:0] currentDetect;
   logic groundFaultDetect, auxSupplyFail, internalFault;
   logic errorIndicator, attention, irq;
   int errorCnt = 0;
   int checkCount = 0;
   int cycles = 0;

   cid_contact_input #(.FILTER_CYCLES(FC)) u_cid_contact_input (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .currentDetect(currentDetect),
      .groundFaultDetect(groundFaultDetect), .auxSupplyFail(auxSupplyFail),
      .internalFault(internalFault), .errorIndicator(errorIndicator),
      .attention(attention), .irq(irq));
   cid_field_model u_cid_field_model (
      .clock(clock), .currentDetect(currentDetect),
      .groundFaultDetect(groundFaultDetect), .auxSupplyFail(auxSupplyFail),
      .internalFault(internalFault));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // ---------------------------------------
   // Bus cycles and comparisons
   // ---------------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [31:0] e, g);
      checkCount++;
      if (g !== e) begin
         errorCnt++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic flag(input string s, input logic e, g);
      chk(s, {31'h0, e}, {31'h0, g});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string s);
      apb(1'b0, a, 32'h0);
      chk(s, e, rdata);
   endtask
   task automatic reportAndStop;
      if (errorCnt == 0 && checkCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errorCnt++;
         reportAndStop;
      end
   end

   // ---------------------------------------
   // Scenarios
   // ---------------------------------------
   initial begin
      {psel, penable, pwrite, rst_n} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      flag("attn reset", 1'b1, attention);
      rd(8'h34, 32'h83C, "status idle");
      wr(8'h34, 32'h1);
      repeat (5) @(posedge clock);
      rd(8'h34, 32'h3D, "status cfg");
      flag("attn cfg", 1'b0, attention);
      wr(8'h40, 32'h7);
      wr(8'h3C, 32'h1);
      u_cid_field_model.settle(16'hA5A5);
      repeat (FC + 8) @(posedge clock);
      rd(8'h00, 32'hA5A5, "inputs");
      flag("irq change", 1'b1, irq);
      wr(8'h40, 32'h1);
      repeat (2) @(posedge clock);
      flag("irq clear", 1'b0, irq);
      u_cid_field_model.bounce(16'hFFFF, FC * 3 / 5);
      repeat (FC + 8) @(posedge clock);
      rd(8'h00, 32'hA5A5, "bounce");
      flag("irq bounce", 1'b0, irq);
      wr(8'h3C, 32'h2);
      u_cid_field_model.faults(1'b1, 1'b0, 1'b0);
      repeat (8) @(posedge clock);
      flag("indicator", 1'b1, errorIndicator);
      flag("attn no alert", 1'b0, attention);
      flag("irq fault", 1'b1, irq);
      rd(8'h34, 32'h23D, "status gnd");
      rd(8'h38, 32'h2, "irq status");
      rd(8'h3C, 32'h2, "irq enable");
      wr(8'h3C, 32'h0);
      repeat (2) @(posedge clock);
      flag("irq mask", 1'b0, irq);
      wr(8'h34, 32'h201);
      repeat (4) @(posedge clock);
      flag("attn alert", 1'b1, attention);
      u_cid_field_model.faults(1'b0, 1'b1, 1'b1);
      wr(8'h34, 32'h3);
      repeat (6) @(posedge clock);
      rd(8'h34, 32'hD3F, "status faults");
      apb(1'b0, 8'h44, 32'h0);
      flag("unmapped err", 1'b1, rerr);
      chk("unmapped data", 32'h0, rdata);
      wr(8'h35, 32'h0);
      flag("unaligned err", 1'b1, rerr);
      u_cid_field_model.faults(1'b0, 1'b0, 1'b0);
      wr(8'h34, 32'h1);
      repeat (6) @(posedge clock);
      flag("attn off", 1'b0, attention);
      wr(8'h34, 32'h0);
      repeat (3) @(posedge clock);
      flag("attn unconfig", 1'b1, attention);
      reportAndStop;
   end
endmodule // tb
`default_nettype wire

/* File: verilog/cid_contact_input.sv */
// Sixteen channel contact input debounce monitor with APB registers
// Behaviour
// - sixteen channels report contact closed on current
// - each channel passes a digital debouncer
// - changes shorter than 3 ms are rejected
// - changes longer than 7 ms are accepted
// - ground fault input means line leaks earth
// - ground fault sets status register flag
// - ground fault lights external error indicator
// - alert enable turns fault into attention
// - internal operating faults are also reported
// - config write, status read, index 13
// - bit 0 configures; clear gives attention
// - bit 1 forces attention, read back
// - status bit 8 shows wetting supply failure
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module cid_debounce #(
   parameter int FILTER_CYCLES = cid_pkg::FILTER_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Raw current detect and filtered state
   input wire logic rawIn,
   output logic state,
   output logic changed
);

   localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_CYCLES - 1);

   logic syncA, syncB;
   logic next_state, next_changed;
   logic [CNT_W-1:0] count, next_count;
   cid_pkg::cid_deb_state_t mode, next_mode;

   // ---------------------------------------------------------------
   // Debounce filter
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_changed = 1'b0;
      next_count = count;
      next_mode = mode;
      case (mode)
         cid_pkg::CID_DEB_IDLE: begin
            next_count = '0;
            if (syncB != state) begin
               next_mode = cid_pkg::CID_DEB_COUNT;
            end
         end
         cid_pkg::CID_DEB_COUNT: begin
            if (syncB == state) begin
               // Too short a change is dropped
               next_mode = cid_pkg::CID_DEB_IDLE;
               next_count = '0;
            end else if (count == CNT_LAST) begin
               // Stable for the window: accept
               next_state = syncB;
               next_changed = 1'b1;
               next_mode = cid_pkg::CID_DEB_IDLE;
               next_count = '0;
            end else begin
               next_count = count + 1'b1;
            end
         end
         default: begin
            next_mode = cid_pkg::CID_DEB_IDLE;
            next_count = '0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= 1'b0;
         syncB <= 1'b0;
         state <= 1'b0;
         changed <= 1'b0;
         count <= '0;
         mode <= cid_pkg::CID_DEB_IDLE;
      end else begin
         syncA <= rawIn;
         syncB <= syncA;
         state <= next_state;
         changed <= next_changed;
         count <= next_count;
         mode <= next_mode;
      end
   end

endmodule // cid_debounce

module cid_contact_input #(
   parameter int NUM_CHANNELS = cid_pkg::NUM_CHANNELS,
   parameter int FILTER_CYCLES = cid_pkg::FILTER_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cid_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Field side detect inputs
   input wire logic [NUM_CHANNELS-1:0] currentDetect,
   input wire logic groundFaultDetect,
   input wire logic auxSupplyFail,
   input wire logic internalFault,
   // Indicators and controller status
   output logic errorIndicator,
   output logic attention,
   output logic irq
);

   localparam int IW = cid_pkg::REG_IDX_W;

   // ---------------------------------------------------------------
   // Channel debouncers
   // ---------------------------------------------------------------
   logic [NUM_CHANNELS-1:0] chanState;
   logic [NUM_CHANNELS-1:0] chanChanged;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
         // Current flowing reads as contact closed
         cid_debounce #(
            .FILTER_CYCLES(FILTER_CYCLES)
         ) u_deb (
            .clock(clock),
            .rst_n(rst_n),
            .rawIn(currentDetect[gi]),
            .state(chanState[gi]),
            .changed(chanChanged[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Fault input synchronisers
   // ---------------------------------------------------------------
   logic [2:0] faultSyncA;
   logic [2:0] faultSyncB;
   logic gndFault, auxFail, intFault;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         faultSyncA <= 3'h0;
         faultSyncB <= 3'h0;
      end else begin
         faultSyncA <= {internalFault, auxSupplyFail, groundFaultDetect};
         faultSyncB <= faultSyncA;
      end
   end

   assign gndFault = faultSyncB[0];
   assign auxFail = faultSyncB[1];
   assign intFault = faultSyncB[2];

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic setup, access, aligned, mapped;
   logic [IW-1:0] regIdx;
   logic wrCfg, wrEnable, wrClear;

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign regIdx = paddr[cid_pkg::APB_ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign mapped = aligned & ((regIdx == cid_pkg::IDX_INPUTS)
      | (regIdx == cid_pkg::IDX_CFG_STATUS)
      | (regIdx == cid_pkg::IDX_IRQ_STATUS)
      | (regIdx == cid_pkg::IDX_IRQ_ENABLE)
      | (regIdx == cid_pkg::IDX_IRQ_CLEAR));
   assign pready = access;
   assign wrCfg = access & pwrite & aligned
      & (regIdx == cid_pkg::IDX_CFG_STATUS);
   assign wrEnable = access & pwrite & aligned
      & (regIdx == cid_pkg::IDX_IRQ_ENABLE);
   assign wrClear = access & pwrite & aligned
      & (regIdx == cid_pkg::IDX_IRQ_CLEAR);

   // ---------------------------------------------------------------
   // Configuration, attention and indicator
   // ---------------------------------------------------------------
   logic [31:0] cfgReg, next_cfgReg;
   logic configured, forceErr, gfAlertEn;
   logic next_attention, next_errorIndicator;

   assign configured = cfgReg[cid_pkg::BIT_CONFIGURE];
   assign forceErr = cfgReg[cid_pkg::BIT_FORCE_ERR];
   assign gfAlertEn = cfgReg[cid_pkg::BIT_GF_ALERT_EN];

   always_comb begin
      next_cfgReg = cfgReg;
      if (wrCfg) begin
         next_cfgReg = pwdata;
      end
      // Alert enable decides whether a ground fault is catastrophic,
      next_attention = ~configured | forceErr | intFault
         | (gfAlertEn & gndFault);
      next_errorIndicator = gndFault | forceErr | intFault;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfgReg <= cid_pkg::CFG_RESET;
         attention <= 1'b0;
         errorIndicator <= 1'b0;
      end else begin
         cfgReg <= next_cfgReg;
         attention <= next_attention;
         errorIndicator <= next_errorIndicator;
      end
   end

   // ---------------------------------------------------------------
   // Status word
   // ---------------------------------------------------------------
   logic [31:0] statusWord;

   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[cid_pkg::BIT_CONFIGURE] = configured;
      statusWord[cid_pkg::BIT_FORCE_ERR] = forceErr;
      statusWord[cid_pkg::BIT_UNDEF_HI:cid_pkg::BIT_UNDEF_LO] = '1;
      statusWord[cid_pkg::BIT_AUX_FAIL] = auxFail;
      statusWord[cid_pkg::BIT_GND_FAULT] = gndFault;
      statusWord[cid_pkg::BIT_INT_FAULT] = intFault;
      statusWord[cid_pkg::BIT_ATTENTION] = attention;
   end

   // ---------------------------------------------------------------
   // Interrupt status, enable and clear
   // ---------------------------------------------------------------
   localparam int NE = cid_pkg::NUM_EVENTS;
   logic [NE-1:0] irqStatus, irqEnable;
   logic [NE-1:0] next_irqStatus, next_irqEnable;
   logic [NE-1:0] events;
   logic gndFaultLast, attentionLast;

   always_comb begin
      events = '0;
      events[cid_pkg::EV_INPUT_CHANGE] = |chanChanged;
      events[cid_pkg::EV_GND_FAULT] = gndFault & ~gndFaultLast;
      events[cid_pkg::EV_ATTENTION] = attention & ~attentionLast;
      next_irqStatus = irqStatus;
      if (wrClear) begin
         next_irqStatus = irqStatus & ~pwdata[NE-1:0];
      end
      // An event in the clearing cycle survives
      next_irqStatus = next_irqStatus | events;
      next_irqEnable = irqEnable;
      if (wrEnable) begin
         next_irqEnable = pwdata[NE-1:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irqStatus <= '0;
         irqEnable <= '0;
         gndFaultLast <= 1'b0;
         attentionLast <= 1'b0;
         irq <= 1'b0;
      end else begin
         irqStatus <= next_irqStatus;
         irqEnable <= next_irqEnable;
         gndFaultLast <= gndFault;
         attentionLast <= attention;
         irq <= |(next_irqStatus & next_irqEnable);
      end
   end

   // ---------------------------------------------------------------
   // Read data, captured in the setup cycle
   // ---------------------------------------------------------------
   logic [31:0] next_prdata;
   logic next_pslverr;

   always_comb begin
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (setup) begin
         next_prdata = 32'h0000_0000;
         next_pslverr = ~mapped;
         if (!pwrite && aligned) begin
            case (regIdx)
               cid_pkg::IDX_INPUTS: begin
                  next_prdata[NUM_CHANNELS-1:0] = chanState;
               end
               cid_pkg::IDX_CFG_STATUS: begin
                  next_prdata = statusWord;
               end
               cid_pkg::IDX_IRQ_STATUS: begin
                  next_prdata[NE-1:0] = irqStatus;
               end
               cid_pkg::IDX_IRQ_ENABLE: begin
                  next_prdata[NE-1:0] = irqEnable;
               end
               default: begin
                  next_prdata = 32'h0000_0000;
               end
            endcase
         end
      end else if (!psel) begin
         next_pslverr = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

endmodule // cid_contact_input

`default_nettype wire

/* File: verilog/cid_pkg.sv */
// Constants shared by the contact input debounce monitor
package cid_pkg;

   // ---------------------------------------------------------------
   // Clock and debounce timing
   // ---------------------------------------------------------------
   localparam int CLK_KHZ = 200000;
   // Longest change that must be rejected, shortest that must pass
   localparam int REJECT_TIME_MS = 3;
   localparam int ACCEPT_TIME_MS = 7;
   // Filter window sits between the two bounds
   localparam int FILTER_TIME_MS = 5;
   localparam int FILTER_CYCLES = CLK_KHZ * FILTER_TIME_MS;

   // ---------------------------------------------------------------
   // Channel count and bus widths
   // ---------------------------------------------------------------
   localparam int NUM_CHANNELS = 16;
   localparam int APB_ADDR_W = 8;
   localparam int REG_IDX_W = APB_ADDR_W - 2;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [REG_IDX_W-1:0] IDX_INPUTS = 6'h00;
   localparam logic [REG_IDX_W-1:0] IDX_CFG_STATUS = 6'h0D;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_STATUS = 6'h0E;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_ENABLE = 6'h0F;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_CLEAR = 6'h10;

   // ---------------------------------------------------------------
   // Configuration (write) and status (read) bit positions
   // ---------------------------------------------------------------
   localparam int BIT_CONFIGURE = 0;
   localparam int BIT_FORCE_ERR = 1;
   localparam int BIT_UNDEF_LO = 2;
   localparam int BIT_UNDEF_HI = 5;
   localparam int BIT_AUX_FAIL = 8;
   localparam int BIT_GND_FAULT = 9;
   localparam int BIT_GF_ALERT_EN = 9;
   localparam int BIT_INT_FAULT = 10;
   localparam int BIT_ATTENTION = 11;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Interrupt event bits
   // ---------------------------------------------------------------
   localparam int NUM_EVENTS = 3;
   localparam int EV_INPUT_CHANGE = 0;
   localparam int EV_GND_FAULT = 1;
   localparam int EV_ATTENTION = 2;

   typedef enum logic [1:0] {
      CID_DEB_IDLE = 2'b00,
      CID_DEB_COUNT = 2'b01
   } cid_deb_state_t;

endpackage
